// ---- mdio_frame_slave.sv ----
// Serial management frame receiver and read-data shifter
`timescale 1ns/10ps
`include "phy_strap_consts.svh"

module mdio_frame_slave #(
   parameter int PREAMBLE_MIN = `MDIO_PREAMBLE_MIN
) (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    mdcPin,
   input  wire logic                    mdioInPin,
   input  wire logic [2:0]              stationAddress,
   input  wire phy_strap_pkg::reg_word_t rdData,
   output logic                         mdioOut,
   output logic                         mdioOe,
   output logic [4:0]                   regAddr,
   output phy_strap_pkg::reg_word_t     wrData,
   output logic                         rdStrobe,
   output logic                         wrStrobe
);

   // Preamble counter saturates at 63, so longer minimums could never be met
   if (PREAMBLE_MIN < 1 || PREAMBLE_MIN > 63) begin : badPreamble
      $error("PREAMBLE_MIN must lie in 1..63");
   end

   // =====================================================================
   // Pin synchronisers
   logic [1:0]                mdcSync;
   logic [1:0]                mdioSync;
   logic                      mdcLast;
   logic                      mdcRise;
   logic                      bitIn;
   phy_strap_pkg::mdio_state_t state;
   logic [5:0]                preambleCount;
   logic [4:0]                bitCount;
   logic [11:0]               header;
   logic [12:0]               fullHeader;
   phy_strap_pkg::reg_word_t  shiftReg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mdcSync  <= 2'h0;
         mdioSync <= 2'h3;
         mdcLast  <= 1'h0;
      end else begin
         mdcSync  <= {mdcSync[0], mdcPin};
         mdioSync <= {mdioSync[0], mdioInPin};
         mdcLast  <= mdcSync[1];
      end
   end

   assign mdcRise    = mdcSync[1] & ~mdcLast;
   assign bitIn      = mdioSync[1];
   assign fullHeader = {header, bitIn};

   // Start bit 1, read or write opcode, upper address bits zero, low bits match
   function automatic logic headerMatch(input logic [12:0] h, input logic [2:0] addr);
      return h[12] && (h[11:10] == `MDIO_OP_READ || h[11:10] == `MDIO_OP_WRITE)
             && h[9:5] == {2'h0, addr};
   endfunction

   // =====================================================================
   // Frame sequencer, advanced on each rising management clock edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state         <= phy_strap_pkg::MDIO_IDLE;
         preambleCount <= 6'h00;
         bitCount      <= 5'h00;
         header        <= 12'h000;
         shiftReg      <= 16'h0000;
         regAddr       <= 5'h00;
         wrData        <= 16'h0000;
         rdStrobe      <= 1'h0;
         wrStrobe      <= 1'h0;
         mdioOut       <= 1'h0;
         mdioOe        <= 1'h0;
      end else begin
         rdStrobe <= 1'h0;
         wrStrobe <= 1'h0;
         if (mdcRise) begin
            case (state)
               phy_strap_pkg::MDIO_IDLE: begin
                  bitCount <= 5'h00;
                  if (bitIn) begin
                     if (preambleCount != 6'h3f) begin
                        preambleCount <= preambleCount + 6'h01;
                     end
                  end else begin
                     preambleCount <= 6'h00;
                     if (preambleCount >= 6'(PREAMBLE_MIN)) begin
                        state <= phy_strap_pkg::MDIO_HEADER;
                     end
                  end
               end
               phy_strap_pkg::MDIO_HEADER: begin
                  header   <= fullHeader[11:0];
                  bitCount <= bitCount + 5'h01;
                  if (bitCount == `MDIO_HDR_LAST) begin
                     bitCount <= 5'h00;
                     regAddr  <= fullHeader[4:0];
                     if (!headerMatch(fullHeader, stationAddress)) begin
                        state <= phy_strap_pkg::MDIO_SKIP;
                     end else if (fullHeader[11:10] == `MDIO_OP_READ) begin
                        rdStrobe <= 1'h1;
                        state    <= phy_strap_pkg::MDIO_TURN;
                     end else begin
                        state <= phy_strap_pkg::MDIO_WRITE;
                     end
                  end
               end
               phy_strap_pkg::MDIO_TURN: begin
                  // Second turnaround bit is driven low
                  mdioOe   <= 1'h1;
                  mdioOut  <= 1'h0;
                  shiftReg <= rdData;
                  state    <= phy_strap_pkg::MDIO_READ;
               end
               phy_strap_pkg::MDIO_READ: begin
                  if (bitCount == `MDIO_DATA_LAST) begin
                     mdioOe  <= 1'h0;
                     mdioOut <= 1'h0;
                     state   <= phy_strap_pkg::MDIO_IDLE;
                  end else begin
                     mdioOut  <= shiftReg[15];
                     shiftReg <= {shiftReg[14:0], 1'h0};
                     bitCount <= bitCount + 5'h01;
                  end
               end
               phy_strap_pkg::MDIO_WRITE: begin
                  // Turnaround bits fall off the top of the shifter
                  shiftReg <= {shiftReg[14:0], bitIn};
                  bitCount <= bitCount + 5'h01;
                  if (bitCount == `MDIO_WR_LAST) begin
                     wrData   <= {shiftReg[14:0], bitIn};
                     wrStrobe <= 1'h1;
                     state    <= phy_strap_pkg::MDIO_IDLE;
                  end
               end
               phy_strap_pkg::MDIO_SKIP: begin
                  bitCount <= bitCount + 5'h01;
                  if (bitCount == `MDIO_WR_LAST) begin
                     state <= phy_strap_pkg::MDIO_IDLE;
                  end
               end
               default: begin
                  state <= phy_strap_pkg::MDIO_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// ---- mdio_host.sv ----
// Management controller model that sends read and write frames
`timescale 1ns/10ps
module mdio_host #(
   parameter int PRE = 4
) (
   input  wire logic clk,
   input  wire logic mdioWire,
   output logic      mdc,
   output logic      mdoHost
);
   // ======================================
   // Frame engine
   // Clock stands low between frames; released data sits at pull-up level
   initial begin
      mdc = 1'b0;
      mdoHost = 1'b1;
   end

   task automatic halfBit();
      repeat (10) @(posedge clk);
      #1;
   endtask

   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] bits;
      bits = {2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      // Fresh preamble before each frame
      for (int i = 0; i < PRE + 32; i++) begin
         if (i < PRE || (op == 2'b10 && i >= PRE + 14)) begin
            mdoHost = 1'b1;
         end else begin
            mdoHost = bits[PRE + 31 - i];
         end
         halfBit();
         // Sample late in the low phase, well after the device moved its data
         if (i >= PRE + 16) begin
            rd = {rd[14:0], mdioWire};
         end
         mdc = 1'b1;
         halfBit();
         mdc = 1'b0;
      end
      mdoHost = 1'b1;
   endtask
endmodule

// ---- phy_strap_consts.svh ----
// Offsets, field positions, reset values and counts of the strap and control registers
`ifndef PHY_STRAP_CONSTS_SVH
`define PHY_STRAP_CONSTS_SVH

// =====================================================================
// Register offsets
`define OFF_STRAP_STATUS    5'h17
`define OFF_EXP_CTRL        5'h18
`define OFF_INT_CTRL        5'h1b

// =====================================================================
// Strap capture status fields
`define STRAP_ADDR_MSB      15
`define STRAP_ADDR_LSB      13
`define STRAP_FILTER_BIT    8
`define STRAP_RELAY_BIT     6
`define STRAP_NAND_BIT      5
`define STRAP_RMII_BIT      1
`define STRAP_RESERVED_MASK 16'h1e9d
`define STRAP_SYNC_CYCLES   2'h2

// =====================================================================
// Expanded control fields
`define EXP_PD_OFF_BIT      11
`define EXP_LATENCY_BIT     10
`define EXP_PRE10_BIT       6
`define EXP_CTRL_RESET      16'h0801

// =====================================================================
// Interrupt control and status fields
`define INT_EN_MSB          15
`define INT_EN_LSB          12
`define INT_STAT_MSB        7
`define INT_STAT_LSB        4
`define INT_EN_RESET        4'h0
`define INT_STAT_RESET      4'h0

// =====================================================================
// Management frame
`define MDIO_PREAMBLE_MIN   32
`define MDIO_HDR_LAST       5'h0c
`define MDIO_DATA_LAST      5'h10
`define MDIO_WR_LAST        5'h11
`define MDIO_OP_READ        2'h2
`define MDIO_OP_WRITE       2'h1

`endif

// ---- phy_strap_pkg.sv ----
// Types shared by the strap and control register block
package phy_strap_pkg;
   typedef logic [15:0] reg_word_t;
   typedef enum logic [2:0] {
      MDIO_IDLE,
      MDIO_HEADER,
      MDIO_TURN,
      MDIO_READ,
      MDIO_WRITE,
      MDIO_SKIP
   } mdio_state_t;
endpackage

// ---- phy_strap_status_and_ctrl_regs.sv ----
// Strap status, expanded control and interrupt control registers behind the management port
`timescale 1ns/10ps
`include "phy_strap_consts.svh"

// Overview of operation
// - Strap status bits 15:13 report latched three-bit station address, read-only.
// - Strap status bit 8 reads 1 when emission line filter was strapped on.
// - Strap status bit 6 reads 1 when back-to-back relay mode was strapped.
// - Strap status bit 5 reads 1 when NAND-chain test mode was strapped.
// - Strap status bit 1 reads 1 when normal reduced interface was strapped.
// - Expanded control bit 11 disables energy-detect power-down; resets to 1.
// - Expanded control bit 10: 0 fixed latency, 1 variable latency; resets 0.
// - Interrupt control bit 15 enables jabber interrupt; resets to 0.
// - Interrupt control bit 14 enables receive-error interrupt; resets to 0.
// - Interrupt control bit 13 enables page-received interrupt; resets to 0.
// - Interrupt control bit 12 enables parallel-detect fault interrupt; resets to 0.
// - Event status bits are read-only, set by events, cleared when read.

module phy_strap_status_and_ctrl_regs #(
   parameter int PREAMBLE_MIN = `MDIO_PREAMBLE_MIN
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       mdcPin,
   input  wire logic       mdioInPin,
   output logic            mdioOut,
   output logic            mdioOe,
   input  wire logic [2:0] stationAddressStrapPin,
   input  wire logic       emissionLineFilterStrapPin,
   input  wire logic       relayBackToBackStrapPin,
   input  wire logic       nandTreeStrapPin,
   input  wire logic       rmiiNormalStrapPin,
   input  wire logic       jabberEvent,
   input  wire logic       rxErrorEvent,
   input  wire logic       pageRxEvent,
   input  wire logic       parallelFaultEvent,
   output logic [2:0]      stationAddressStrap,
   output logic            emissionLineFilter,
   output logic            relayBackToBack,
   output logic            nandTreeMode,
   output logic            rmiiNormalMode,
   output logic            energyDetectPowerDownOff,
   output logic            rxLatencyVariable,
   output logic            preamble10Enable,
   output logic            interruptOut
);

   // =====================================================================
   // Declarations
   logic [6:0]                strapSync1;
   logic [6:0]                strapSync2;
   logic [1:0]                loadCount;
   logic                      strapsLoaded;
   phy_strap_pkg::reg_word_t  expCtrl_reg;
   logic [3:0]                intEnable_reg;
   logic [3:0]                intStatus_reg;
   logic [3:0]                intStatus_next;
   logic [3:0]                eventsIn;
   phy_strap_pkg::reg_word_t  rdData_reg;
   logic [4:0]                regAddr;
   phy_strap_pkg::reg_word_t  wrData;
   logic                      rdStrobe;
   logic                      wrStrobe;
   logic                      noExpWrite_reg;

   // =====================================================================
   // Management frame front end
   mdio_frame_slave #(
      .PREAMBLE_MIN (PREAMBLE_MIN)
   ) frameSlave (
      .clk            (clk),
      .reset_n        (reset_n),
      .mdcPin         (mdcPin),
      .mdioInPin      (mdioInPin),
      .stationAddress (stationAddressStrap),
      .rdData         (rdData_reg),
      .mdioOut        (mdioOut),
      .mdioOe         (mdioOe),
      .regAddr        (regAddr),
      .wrData         (wrData),
      .rdStrobe       (rdStrobe),
      .wrStrobe       (wrStrobe)
   );

   // =====================================================================
   // Strap capture
   // Straps are loaded once, three cycles after release, so the pins have
   // passed the synchroniser; afterwards the pins are ignored.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strapSync1 <= 7'h00;
         strapSync2 <= 7'h00;
      end else begin
         strapSync1 <= {stationAddressStrapPin, emissionLineFilterStrapPin,
                        relayBackToBackStrapPin, nandTreeStrapPin, rmiiNormalStrapPin};
         strapSync2 <= strapSync1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         loadCount           <= 2'h0;
         strapsLoaded        <= 1'h0;
         stationAddressStrap <= 3'h0;
         emissionLineFilter  <= 1'h0;
         relayBackToBack     <= 1'h0;
         nandTreeMode        <= 1'h0;
         rmiiNormalMode      <= 1'h0;
      end else if (!strapsLoaded) begin
         if (loadCount == `STRAP_SYNC_CYCLES) begin
            strapsLoaded        <= 1'h1;
            stationAddressStrap <= strapSync2[6:4];
            emissionLineFilter  <= strapSync2[3];
            relayBackToBack     <= strapSync2[2];
            nandTreeMode        <= strapSync2[1];
            rmiiNormalMode      <= strapSync2[0];
         end else begin
            loadCount <= loadCount + 2'h1;
         end
      end
   end

   // =====================================================================
   // Expanded control
   // Reserved bits are kept as plain storage so they read back as written
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         expCtrl_reg    <= `EXP_CTRL_RESET;
         noExpWrite_reg <= 1'h1;
      end else if (wrStrobe && regAddr == `OFF_EXP_CTRL) begin
         expCtrl_reg    <= wrData;
         noExpWrite_reg <= 1'h0;
      end
   end

   assign energyDetectPowerDownOff = expCtrl_reg[`EXP_PD_OFF_BIT];
   assign rxLatencyVariable        = expCtrl_reg[`EXP_LATENCY_BIT];
   assign preamble10Enable         = expCtrl_reg[`EXP_PRE10_BIT];

   // =====================================================================
   // Interrupt enables, event status and output
   assign eventsIn = {jabberEvent, rxErrorEvent, pageRxEvent, parallelFaultEvent};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         intEnable_reg <= `INT_EN_RESET;
      end else if (wrStrobe && regAddr == `OFF_INT_CTRL) begin
         intEnable_reg <= wrData[`INT_EN_MSB:`INT_EN_LSB];
      end
   end

   // An event in the very cycle of a clearing read survives the read
   always_comb begin
      intStatus_next = intStatus_reg;
      if (rdStrobe && regAddr == `OFF_INT_CTRL) begin
         intStatus_next = 4'h0;
      end
      intStatus_next = intStatus_next | eventsIn;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         intStatus_reg <= `INT_STAT_RESET;
      end else begin
         intStatus_reg <= intStatus_next;
      end
   end

   // One cycle behind the status flags, keeping the output a flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         interruptOut <= 1'h0;
      end else begin
         interruptOut <= |(intStatus_reg & intEnable_reg);
      end
   end

   // =====================================================================
   // Read data
   function automatic phy_strap_pkg::reg_word_t readWord(input logic [4:0] addr);
      phy_strap_pkg::reg_word_t w;
      w = 16'h0000;
      case (addr)
         `OFF_STRAP_STATUS: begin
            w[`STRAP_ADDR_MSB:`STRAP_ADDR_LSB] = stationAddressStrap;
            w[`STRAP_FILTER_BIT]               = emissionLineFilter;
            w[`STRAP_RELAY_BIT]                = relayBackToBack;
            w[`STRAP_NAND_BIT]                 = nandTreeMode;
            w[`STRAP_RMII_BIT]                 = rmiiNormalMode;
         end
         `OFF_EXP_CTRL: begin
            w = expCtrl_reg;
         end
         `OFF_INT_CTRL: begin
            w[`INT_EN_MSB:`INT_EN_LSB]     = intEnable_reg;
            w[`INT_STAT_MSB:`INT_STAT_LSB] = intStatus_reg;
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_reg <= 16'h0000;
      end else if (rdStrobe) begin
         rdData_reg <= readWord(regAddr);
      end
   end

   // =====================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence readOf(logic [4:0] a);
      rdStrobe && regAddr == a;
   endsequence

   sequence writeOf(logic [4:0] a);
      wrStrobe && regAddr == a;
   endsequence

   chk_strap_addr_read: assert property (
      readOf(`OFF_STRAP_STATUS) |=> rdData_reg[15:13] == stationAddressStrap
         && (rdData_reg & `STRAP_RESERVED_MASK) == 16'h0000)
      else $error("strap address field misreported");

   chk_filter_strap_read: assert property (
      readOf(`OFF_STRAP_STATUS) |=> rdData_reg[8] == emissionLineFilter)
      else $error("line filter strap misreported");

   chk_relay_strap_read: assert property (
      readOf(`OFF_STRAP_STATUS) |=> rdData_reg[6] == relayBackToBack)
      else $error("relay strap misreported");

   chk_nand_strap_read: assert property (
      readOf(`OFF_STRAP_STATUS) |=> rdData_reg[5] == nandTreeMode)
      else $error("NAND test strap misreported");

   chk_rmii_strap_read: assert property (
      readOf(`OFF_STRAP_STATUS) |=> rdData_reg[1] == rmiiNormalMode)
      else $error("normal interface strap misreported");

   chk_pd_off_write: assert property (
      writeOf(`OFF_EXP_CTRL) |=> energyDetectPowerDownOff == $past(wrData[11])
         ##1 energyDetectPowerDownOff == $past(wrData[11], 2) || $past(wrStrobe))
      else $error("power-down disable bit not written");

   chk_pd_off_reset: assert property (
      noExpWrite_reg |-> energyDetectPowerDownOff && !rxLatencyVariable)
      else $error("expanded control reset value wrong");

   chk_latency_write: assert property (
      writeOf(`OFF_EXP_CTRL) |=> rxLatencyVariable == $past(wrData[10]))
      else $error("latency bit not written");

   chk_jabber_enable: assert property (
      writeOf(`OFF_INT_CTRL) |=> intEnable_reg[3] == $past(wrData[15]))
      else $error("jabber enable not written");

   chk_rxerr_enable: assert property (
      writeOf(`OFF_INT_CTRL) |=> intEnable_reg[2] == $past(wrData[14]))
      else $error("receive error enable not written");

   chk_page_enable: assert property (
      writeOf(`OFF_INT_CTRL) |=> intEnable_reg[1] == $past(wrData[13]))
      else $error("page enable not written");

   chk_fault_enable: assert property (
      writeOf(`OFF_INT_CTRL) |=> intEnable_reg[0] == $past(wrData[12]))
      else $error("parallel fault enable not written");

   chk_event_sticky: assert property (
      jabberEvent |=> intStatus_reg[3])
      else $error("jabber event not latched");

   chk_status_clear: assert property (
      readOf(`OFF_INT_CTRL) ##0 eventsIn == 4'h0 |=> intStatus_reg == 4'h0
         ##0 rdData_reg[7:4] == $past(intStatus_reg))
      else $error("status not cleared by read");

   chk_strap_hold: assert property (
      strapsLoaded |=> strapsLoaded && $stable(stationAddressStrap)
         && $stable(relayBackToBack) && $stable(emissionLineFilter)
         && $stable(nandTreeMode) && $stable(rmiiNormalMode))
      else $error("strap value changed after capture");

   chk_int_output: assert property (
      |(intStatus_reg & intEnable_reg) |=> interruptOut)
      else $error("interrupt output missing");

   chk_int_quiet: assert property (
      !(|(intStatus_reg & intEnable_reg)) |=> !interruptOut)
      else $error("interrupt output without enabled cause");

endmodule

// ---- tb_top.sv ----
// Self-checking bench for the strap status and control register block
`timescale 1ns/10ps
module tb_top;
   logic        clk, reset_n, mdc, mdoHost, mdioOut, mdioOe;
   logic [6:0]  strapPins, strapOut, lStrap;
   logic [2:0]  ctrlOut;
   logic [3:0]  ev;
   logic        irq;
   logic [15:0] rd, v, sw;
   logic [31:0] rng = 32'hc501e1bd;
   int          bad_count = 0;
   int          total_checks = 0;
   int          mExp, mEn, mStat;
   wire logic   mdioWire = mdioOe ? mdioOut : mdoHost;

   phy_strap_status_and_ctrl_regs #(.PREAMBLE_MIN(4)) i_dut (.clk(clk), .reset_n(reset_n),
      .mdcPin(mdc), .mdioInPin(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .stationAddressStrapPin(strapPins[6:4]), .emissionLineFilterStrapPin(strapPins[3]),
      .relayBackToBackStrapPin(strapPins[2]), .nandTreeStrapPin(strapPins[1]),
      .rmiiNormalStrapPin(strapPins[0]), .jabberEvent(ev[3]), .rxErrorEvent(ev[2]),
      .pageRxEvent(ev[1]), .parallelFaultEvent(ev[0]), .stationAddressStrap(strapOut[6:4]),
      .emissionLineFilter(strapOut[3]), .relayBackToBack(strapOut[2]),
      .nandTreeMode(strapOut[1]), .rmiiNormalMode(strapOut[0]),
      .energyDetectPowerDownOff(ctrlOut[2]), .rxLatencyVariable(ctrlOut[1]),
      .preamble10Enable(ctrlOut[0]), .interruptOut(irq));
   mdio_host #(.PRE(4)) i_host (.clk(clk), .mdioWire(mdioWire), .mdc(mdc), .mdoHost(mdoHost));

   // ======================================
   // Helpers
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Register model: expected read word from strap copy and shadow values
   function automatic logic [15:0] modelRead(input logic [4:0] ra);
      case (ra)
         5'h17: return sw;
         5'h18: return 16'(mExp);
         5'h1b: return {4'(mEn), 4'h0, 4'(mStat), 4'h0};
         default: return 16'h0000;
      endcase
   endfunction
   task automatic acc(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] e;
      e = modelRead(ra);
      i_host.frame(op, {2'b00, lStrap[6:4]}, ra, wd, rd);
      if (op == 2'b10) begin
         chk(rd, e, "model read");
         if (ra == 5'h1b) begin
            mStat = 0;
         end
      end else if (ra == 5'h18) begin
         mExp = int'(wd);
      end else if (ra == 5'h1b) begin
         mEn = int'(wd[15:12]);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      summarize();
   end

   // ======================================
   // Tests
   initial begin
      reset_n = 1'b0;
      ev = 4'h0;
      strapPins = 7'h00;
      for (int r = 0; r < 3; r++) begin
         @(posedge clk);
         #1 reset_n = 1'b0;
         mExp = 32'h0000_0801;
         mEn = 0;
         mStat = 0;
         strapPins = 7'(xs());
         lStrap = strapPins;
         repeat (6) @(posedge clk);
         #1 reset_n = 1'b1;
         repeat (10) @(posedge clk);
         sw = {lStrap[6:4], 4'h0, lStrap[3], 1'b0, lStrap[2:1], 3'h0, lStrap[0], 1'b0};
         chk({9'h000, strapOut}, {9'h000, lStrap}, "strap out");
         chk({13'h0000, ctrlOut}, 16'h0004, "ctrl out");
         acc(2'b10, 5'h17, 16'h0000);
         chk(rd, sw, "strap reg");
         acc(2'b10, 5'h18, 16'h0000);
         chk(rd, 16'h0801, "exp reset");
         acc(2'b10, 5'h1b, 16'h0000);
         chk(rd, 16'h0000, "int reset");
         strapPins = ~lStrap;
         acc(2'b01, 5'h17, 16'(xs()));
         acc(2'b10, 5'h17, 16'h0000);
         chk(rd, sw, "strap held");
         i_host.frame(2'b10, {2'b00, ~lStrap[6:4]}, 5'h17, 16'h0000, rd);
         chk(rd, 16'hffff, "wrong phy");
         acc(2'b10, 5'h1c, 16'h0000);
         chk(rd, 16'h0000, "unmapped");
         for (int k = 0; k < 4; k++) begin
            v = 16'(xs());
            if (lStrap[2]) begin
               v[6] = 1'b1;
            end
            acc(2'b01, 5'h18, v);
            acc(2'b10, 5'h18, 16'h0000);
            chk(rd, v, "exp rw");
            chk({13'h0000, ctrlOut}, {13'h0000, v[11:10], v[6]}, "ctrl bits");
            v = {4'(xs()), 12'h000};
            acc(2'b01, 5'h1b, v | 16'h0ff0);
            @(posedge clk);
            #1 ev[k] = 1'b1;
            mStat = mStat | (1 << k);
            @(posedge clk);
            #1 ev = 4'h0;
            repeat (3) @(posedge clk);
            chk({15'h0000, irq}, {15'h0000, v[12 + k]}, "irq level");
            acc(2'b10, 5'h1b, 16'h0000);
            chk(rd, v | (16'h0010 << k), "int set");
            acc(2'b10, 5'h1b, 16'h0000);
            chk(rd, v, "int clear");
            chk({15'h0000, irq}, 16'h0000, "irq clear");
         end
         $display("test %0d done", r);
      end
      summarize();
   end
endmodule
